// >>> common/rst_seq_pkg.sv
// Package: constants and types for the reset release sequencer
package rst_seq_pkg;
    // AHB-Lite register byte offsets
    localparam logic [7:0] reg_ctrl_off = 8'h00;
    localparam logic [7:0] reg_cause_off = 8'h04;
    localparam logic [7:0] reg_osc_off = 8'h08;
    localparam logic [7:0] reg_status_off = 8'h0c;
    // Reset cause register bit positions
    localparam int cause_trap_bit = 15;
    localparam int cause_iop_bit = 14;
    localparam int cause_master_clear_pin_bit = 7;
    localparam int cause_swr_bit = 6;
    localparam int cause_wdt_bit = 4;
    localparam int cause_bor_bit = 1;
    localparam int cause_por_bit = 0;
    localparam logic [15:0] cause_rst_val = 16'h0003;
    localparam logic [15:0] cause_wr_mask = 16'hc0ff;
    // Oscillator control field positions
    localparam int osc_cur_lsb = 12;
    localparam int osc_new_lsb = 8;
    localparam logic [15:0] osc_rst_val = 16'h0000;
    localparam logic [15:0] ctrl_rst_val = 16'h0000;
    // Timing: times as printed, counts at 100 MHz
    localparam int clk_mhz = 100;
    localparam int t_por_us = 10;
    localparam int t_startup_us = 20;
    localparam int t_power_up_timer_ms = 64;
    localparam int t_rst_us = 20;
    localparam int t_lock_us = 20;
    localparam int t_clock_fail_monitor_us = 100;
    localparam int por_cyc = t_por_us * clk_mhz;
    localparam int startup_cyc = t_startup_us * clk_mhz;
    localparam int power_up_timer_cyc = t_power_up_timer_ms * 1000 * clk_mhz;
    localparam int rst_cyc = t_rst_us * clk_mhz;
    localparam int lock_cyc = t_lock_us * clk_mhz;
    localparam int clock_fail_monitor_cyc = t_clock_fail_monitor_us * clk_mhz;
    localparam int ost_periods = 1024;
    localparam int ost_w = 10;
    localparam logic [2:0] osc_frc = 3'h0;
    // Clock source kinds
    typedef enum logic [2:0] {
        src_ext, src_frc, src_low_power_rc_clock, src_ext_pll, src_frc_pll,
        src_xtal, src_xtal_pll
    } osc_kind_type;
    // Reset sources as one bundle
    typedef struct packed {
        logic por;
        logic bor;
        logic master_clear_pin;
        logic software_reset;
        logic wdt;
        logic trap;
        logic iop;
    } rst_src_type;
    // Outputs toward the CPU core and clock system
    typedef struct packed {
        logic sys_reset;
        logic clk_release;
        logic run;
        logic monitor_on;
        logic osc_fail_trap;
        logic [2:0] clk_sel;
    } core_out_type;
endpackage

// >>> design/osc_startup_timer.sv
// Oscillator start-up timer: counts 1024 oscillator periods
`timescale 1ns/10ps
module osc_startup_timer
    import rst_seq_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Control
    input wire logic start,
    input wire logic osc_tick,
    // Status
    output logic done
);
    logic [ost_w-1:0] cnt_q;
    logic run_q;

    // 10-bit counter; wrap after the last period marks done
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= '0;
            run_q <= 1'b0;
            done <= 1'b0;
        end else if (start) begin
            cnt_q <= '0;
            run_q <= 1'b1;
            done <= 1'b0;
        end else if (run_q && osc_tick) begin
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q == ost_w'(ost_periods - 1)) begin
                run_q <= 1'b0;
                done <= 1'b1;
            end
        end
    end
endmodule

// >>> design/reset_release_sequencer.sv
// Reset release sequencer with AHB-Lite register access
// Contract
// - Switching on: POR/BOR new field, else current
// - Switching off: clock from configuration bits
// - Release reset after power-on and power-up delays
// - Oscillator and PLL waits run alongside delay
// - POR holds power-on, start-up, state reset
// - Start-up 20us with regulator, else 64ms
// - Wake applies start-up delay if regulator on
// - Other resets hold only state reset time
// - POR clock delay chosen by clock kind
// - Start-up timer counts 1024 oscillator periods
// - PLL modes wait PLL lock time
// - Crystal/PLL delay clock monitoring start
// - No execution before clock is released
// - Failed clock at monitor start: switch, trap
// - Other registers reset alike for all types
// - Cause and oscillator reset values vary
// - Any reset forces program counter to zero
// - Any active source asserts system reset
// - Sources set flags; POR clears others
//
// Local design decisions: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module reset_release_sequencer
    import rst_seq_pkg::*;
#(
    parameter int por_cycles = por_cyc,
    parameter int startup_cycles = startup_cyc,
    parameter int power_up_timer_cycles = power_up_timer_cyc,
    parameter int rst_cycles = rst_cyc,
    parameter int lock_cycles = lock_cyc,
    parameter int clock_fail_monitor_cycles = clock_fail_monitor_cyc
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic hready,
    // Reset sources and configuration
    input wire rst_src_type rst_src,
    input wire logic wake,
    input wire logic regulator_en,
    input wire logic [2:0] new_osc_config_field,
    input wire osc_kind_type osc_kind,
    input wire logic clk_switch_en,
    input wire logic fail_monitor_en,
    input wire logic osc_tick,
    input wire logic pll_locked,
    input wire logic clock_valid,
    // Core and clock system
    output core_out_type core_out,
    output logic [23:0] pc_reset
);
    typedef enum logic [2:0] {
        st_hold, st_clk_wait, st_clock_fail_monitor, st_run
    } seq_state_type;
    seq_state_type state_q;
    logic [31:0] cnt_q;
    logic [31:0] clock_fail_monitor_q;
    logic [31:0] lock_q;
    logic [15:0] cause_q;
    logic [15:0] osc_q;
    logic [15:0] ctrl_q;
    logic any_src;
    logic src_q;
    logic new_src;
    logic is_por;
    logic ost_start;
    logic ost_done;
    logic need_ost;
    logic need_pll;
    logic clk_ok;
    logic [31:0] hold_cycles;
    logic wr_pend_q;
    logic [7:0] addr_q;
    logic [2:0] sel_clk;
    // Assertion clock and reset
    default clocking assert_clk @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    assign any_src = |rst_src;
    assign is_por = rst_src.por | rst_src.bor;
    assign new_src = any_src & ~src_q;
    assign need_ost = (osc_kind == src_xtal) || (osc_kind == src_xtal_pll);
    assign need_pll = (osc_kind == src_ext_pll) || (osc_kind == src_frc_pll)
        || (osc_kind == src_xtal_pll);
    assign ost_start = new_src & rst_src.por;
    // Hold length per source kind
    always_comb begin
        if (rst_src.por) begin
            hold_cycles = 32'(por_cycles + rst_cycles
                + (regulator_en ? startup_cycles : power_up_timer_cycles));
        end else if (wake && regulator_en) begin
            hold_cycles = 32'(startup_cycles);
        end else begin
            hold_cycles = 32'(rst_cycles);
        end
    end
    // Clock select: per reset type when switching enabled
    always_comb begin
        if (!clk_switch_en) begin
            sel_clk = new_osc_config_field;
        end else if (is_por) begin
            sel_clk = new_osc_config_field;
        end else begin
            sel_clk = osc_q[osc_cur_lsb +: 3];
        end
    end

    osc_startup_timer u_ost (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(ost_start),
        .osc_tick(osc_tick),
        .done(ost_done)
    );

    // Source edge tracker
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_q <= 1'b0;
        end else begin
            src_q <= any_src;
        end
    end
    // PLL lock wait, parallel to reset hold
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_q <= '0;
        end else if (rst_src.por) begin
            lock_q <= 32'(lock_cycles);
        end else if (lock_q != '0 && pll_locked) begin
            lock_q <= lock_q - 1'b1;
        end
    end
    assign clk_ok = (!need_ost || ost_done) && (!need_pll || lock_q == '0);
    // Release sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= st_hold;
            cnt_q <= 32'(rst_cycles);
            clock_fail_monitor_q <= '0;
            core_out <= '0;
            pc_reset <= 24'h000000;
        end else begin
            core_out.clk_sel <= core_out.osc_fail_trap ? osc_frc : sel_clk;
            if (new_src || (wake && regulator_en && state_q == st_run)) begin
                state_q <= st_hold;
                cnt_q <= hold_cycles;
                core_out.sys_reset <= 1'b1;
                core_out.run <= 1'b0;
                core_out.clk_release <= 1'b0;
                core_out.monitor_on <= 1'b0;
                core_out.osc_fail_trap <= 1'b0;
                pc_reset <= 24'h000000;
                clock_fail_monitor_q <= (rst_src.por && (need_ost || need_pll))
                    ? 32'(clock_fail_monitor_cycles) : '0;
            end else begin
                case (state_q)
                    st_hold: begin
                        core_out.sys_reset <= 1'b1;
                        if (any_src) begin
                            cnt_q <= cnt_q;
                        end else if (cnt_q > 32'd1) begin
                            cnt_q <= cnt_q - 1'b1;
                        end else begin
                            core_out.sys_reset <= 1'b0;
                            state_q <= st_clk_wait;
                        end
                    end
                    st_clk_wait: begin
                        if (clock_fail_monitor_q != '0) begin
                            clock_fail_monitor_q <= clock_fail_monitor_q - 1'b1;
                        end
                        if (clk_ok) begin
                            core_out.clk_release <= 1'b1;
                            core_out.run <= 1'b1;
                            state_q <= st_clock_fail_monitor;
                        end else if (clock_fail_monitor_q <= 32'd1 && fail_monitor_en
                            && !clock_valid) begin
                            core_out.osc_fail_trap <= 1'b1;
                            core_out.clk_release <= 1'b1;
                            core_out.run <= 1'b1;
                            core_out.monitor_on <= 1'b1;
                            state_q <= st_run;
                        end
                    end
                    st_clock_fail_monitor: begin
                        if (clock_fail_monitor_q > 32'd1) begin
                            clock_fail_monitor_q <= clock_fail_monitor_q - 1'b1;
                        end else begin
                            clock_fail_monitor_q <= '0;
                            core_out.monitor_on <= fail_monitor_en;
                            if (fail_monitor_en && !clock_valid) begin
                                core_out.osc_fail_trap <= 1'b1;
                            end
                            state_q <= st_run;
                        end
                    end
                    st_run: begin
                        core_out.run <= 1'b1;
                    end
                    default: begin
                        state_q <= st_hold;
                    end
                endcase
            end
        end
    end

    // Release sequencer checks
    a_hold_release: assert property (
        $fell(core_out.sys_reset) |-> $past(state_q) == st_hold
        && $past(cnt_q) <= 32'd1) else $error("reset released early");
    a_no_run_early: assert property (
        core_out.run |-> !core_out.sys_reset && core_out.clk_release)
        else $error("run before clock release");
    a_src_asserts: assert property (
        $rose(any_src) |=> core_out.sys_reset)
        else $error("source did not assert reset");
    a_pc_zero: assert property (
        core_out.sys_reset |-> pc_reset == 24'h000000)
        else $error("program counter not zero");
    a_trap_frc: assert property (
        $rose(core_out.osc_fail_trap) |=> core_out.clk_sel == osc_frc)
        else $error("trap without switch");
    a_other_hold: assert property (
        $rose(rst_src.master_clear_pin) && !rst_src.por && !wake
        |=> cnt_q == 32'(rst_cycles)) else $error("hold length wrong");
    a_sel_noswitch: assert property (
        !clk_switch_en && !core_out.osc_fail_trap
        |=> core_out.clk_sel == $past(new_osc_config_field))
        else $error("clock select wrong");

    // Reset cause flags: set wins over software write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cause_q <= cause_rst_val;
        end else begin
            if (wr_pend_q && addr_q == reg_cause_off) begin
                cause_q <= hwdata[15:0] & cause_wr_mask;
            end
            if (rst_src.por) begin
                cause_q <= cause_rst_val;
            end else begin
                if (rst_src.bor) begin
                    cause_q[cause_bor_bit] <= 1'b1;
                    cause_q[cause_trap_bit] <= 1'b0;
                    cause_q[cause_iop_bit] <= 1'b0;
                    cause_q[cause_swr_bit] <= 1'b0;
                    cause_q[cause_wdt_bit] <= 1'b0;
                end
                if (rst_src.master_clear_pin) cause_q[cause_master_clear_pin_bit] <= 1'b1;
                if (rst_src.software_reset) cause_q[cause_swr_bit] <= 1'b1;
                if (rst_src.wdt) cause_q[cause_wdt_bit] <= 1'b1;
                if (rst_src.trap) cause_q[cause_trap_bit] <= 1'b1;
                if (rst_src.iop) cause_q[cause_iop_bit] <= 1'b1;
            end
        end
    end
    // Power-on leaves only its own flags
    a_por_flag: assert property (
        rst_src.por |=> cause_q == cause_rst_val)
        else $error("power-on flags wrong");
    // Oscillator control: current field reloaded on POR/BOR
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_q <= osc_rst_val;
        end else if (is_por) begin
            osc_q[osc_cur_lsb +: 3] <= new_osc_config_field;
            osc_q[osc_new_lsb +: 3] <= new_osc_config_field;
        end else if (core_out.osc_fail_trap) begin
            osc_q[osc_cur_lsb +: 3] <= osc_frc;
        end else if (wr_pend_q && addr_q == reg_osc_off) begin
            osc_q[osc_new_lsb +: 3] <= hwdata[osc_new_lsb +: 3];
        end
    end
    // General control: same reset value for all types
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= ctrl_rst_val;
        end else if (any_src) begin
            ctrl_q <= ctrl_rst_val;
        end else if (wr_pend_q && addr_q == reg_ctrl_off) begin
            ctrl_q <= hwdata[15:0];
        end
    end
    // AHB-Lite: zero wait states, OKAY always
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            addr_q <= '0;
            hrdata <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend_q <= hsel && hready && htrans[1] && hwrite;
            addr_q <= haddr;
            if (hsel && hready && htrans[1] && !hwrite) begin
                case (haddr)
                    reg_ctrl_off: hrdata <= {16'h0000, ctrl_q};
                    reg_cause_off: hrdata <= {16'h0000, cause_q};
                    reg_osc_off: hrdata <= {16'h0000, osc_q};
                    reg_status_off: hrdata <= {24'h000000, 2'b00,
                        core_out.clk_sel, core_out.osc_fail_trap,
                        core_out.monitor_on, core_out.run};
                    default: hrdata <= '0;
                endcase
            end
        end
    end

endmodule

// >>> sim/osc_pll_model.sv
// Oscillator tick, PLL lock and clock-valid model at the far side
`timescale 1ns/10ps
module osc_pll_model (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bench controls and system reset watch
    input wire logic sys_reset,
    input wire logic [7:0] tick_div,
    input wire logic [7:0] lock_dly,
    input wire logic osc_good,
    // Toward the sequencer
    output logic osc_tick,
    output logic pll_locked,
    output logic clock_valid
);
    logic [7:0] div_q;
    logic [7:0] lock_q;
    // One tick per oscillator period, none while the oscillator is dead
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_q <= 8'h00;
            osc_tick <= 1'b0;
        end else begin
            div_q <= (div_q + 8'h01 >= tick_div) ? 8'h00 : div_q + 8'h01;
            osc_tick <= osc_good && (div_q == 8'h00);
        end
    end
    // Lock lost during system reset, regained lock_dly cycles later
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_q <= 8'hff;
        end else if (sys_reset) begin
            lock_q <= lock_dly;
        end else if (lock_q != 8'h00) begin
            lock_q <= lock_q - 8'h01;
        end
    end
    // Lock only shows once the count ran out
    assign pll_locked = (lock_q == 8'h00) && !sys_reset;
    assign clock_valid = osc_good;
endmodule

// >>> sim/reset_release_sequencer_tb_top.sv
// Self-checking bench for the reset release sequencer
`timescale 1ns/10ps
module reset_release_sequencer_tb_top import rst_seq_pkg::*;;
    localparam int pc = 8;
    localparam int sc = 6;
    localparam int pw = 40;
    localparam int rc = 5;
    localparam int lc = 10;
    localparam int fc = 12;
    localparam logic [6:0] por = 7'b1000000;
    localparam logic [6:0] master_clear_pin = 7'b0010000;
    logic hclk = 1'b0;
    logic hresetn, hsel, hwrite, hready, hreadyout, hresp, wake;
    logic regulator_en, clk_switch_en, fail_monitor_en, osc_good;
    logic osc_tick, pll_locked, clock_valid;
    logic [7:0] haddr, tick_div, lock_dly;
    logic [1:0] htrans;
    logic [2:0] hsize, new_osc_config_field;
    logic [31:0] hwdata, hrdata;
    logic [23:0] pc_reset;
    rst_src_type rst_src;
    osc_kind_type osc_kind;
    core_out_type core_out;
    int miscompares = 0;
    int comparisons = 0;
    int bits[5] = '{cause_master_clear_pin_bit, cause_swr_bit, cause_wdt_bit,
        cause_trap_bit, cause_iop_bit};

    assign hready = hreadyout;
    always #5 hclk = ~hclk;

    reset_release_sequencer #(.por_cycles(pc), .startup_cycles(sc),
        .power_up_timer_cycles(pw), .rst_cycles(rc), .lock_cycles(lc),
        .clock_fail_monitor_cycles(fc)) u_dut (.hclk, .hresetn, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata, .hrdata, .hreadyout, .hresp,
        .hready, .rst_src, .wake, .regulator_en, .new_osc_config_field,
        .osc_kind, .clk_switch_en, .fail_monitor_en, .osc_tick,
        .pll_locked, .clock_valid, .core_out, .pc_reset);

    osc_pll_model u_osc (.hclk, .hresetn, .sys_reset(core_out.sys_reset),
        .tick_div, .lock_dly, .osc_good, .osc_tick, .pll_locked,
        .clock_valid);

    // Compare and count
    task check(input string w, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", w, e, s);
        end
    endtask
    function automatic logic [31:0] rng(int n, int lo, int hi);
        return {31'h0, n >= lo && n <= hi};
    endfunction
    // Verdict and end of run
    task results();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // One single-word AHB-Lite transfer, waits on hready
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] e, input string w);
        logic [31:0] d;
        ahb(1'b0, a, 32'h0, d);
        check(w, d, e);
    endtask
    // Raise a source for four cycles; system reset must be up by then
    task pulse(input rst_src_type s, input logic w);
        @(posedge hclk);
        rst_src <= s;
        wake <= w;
        repeat (3) @(posedge hclk);
        @(negedge hclk);
        check("sys_reset on", {31'h0, core_out.sys_reset}, 1);
        @(posedge hclk);
        rst_src <= '0;
        wake <= 1'b0;
    endtask
    // Cycles until bit k of core_out settles (bit 7 low, others high)
    task waitfor(input int k, output int n);
        n = 0;
        while (core_out[k] !== (k != 7) && n < 9000) begin
            @(negedge hclk);
            n++;
        end
    endtask
    // Source pulse, then hold length against the expected count
    task fire(input rst_src_type s, input logic w, input int e,
        input string what);
        int n;
        pulse(s, w);
        waitfor(7, n);
        check(what, rng(n, e - 1, e + 3), 1);
    endtask

    // Hang guard
    initial begin
        #200000;
        miscompares++;
        results();
    end

    initial begin
        logic [31:0] d;
        int n;
        int m;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        rst_src = '0;
        wake = 1'b0;
        regulator_en = 1'b1;
        new_osc_config_field = 3'h0;
        osc_kind = src_ext;
        clk_switch_en = 1'b0;
        fail_monitor_en = 1'b1;
        osc_good = 1'b1;
        tick_div = 8'h02;
        lock_dly = 8'h04;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        waitfor(5, n);
        // Register reset values, unmapped place, write masks
        rchk(reg_cause_off, {16'h0, cause_rst_val}, "cause rst");
        rchk(reg_osc_off, {16'h0, osc_rst_val}, "osc rst");
        rchk(reg_ctrl_off, {16'h0, ctrl_rst_val}, "ctrl rst");
        ahb(1'b1, 8'h10, 32'hffffffff, d);
        rchk(8'h10, 32'h0, "unmapped");
        ahb(1'b1, reg_ctrl_off, 32'hffff1234, d);
        rchk(reg_ctrl_off, 32'h1234, "ctrl rw");
        ahb(1'b1, reg_cause_off, 32'hffff, d);
        rchk(reg_cause_off, {16'h0, cause_wr_mask}, "cause wr");
        check("no reset", {31'h0, core_out.sys_reset}, 0);
        check("pc zero", {8'h0, pc_reset}, 0);
        check("okay", {31'h0, hresp}, 0);
        // Short sources: state-reset hold and own flag
        for (int i = 0; i < 5; i++) begin
            ahb(1'b1, reg_cause_off, 32'h0, d);
            fire(master_clear_pin >> i, 1'b0, rc, "short hold");
            rchk(reg_cause_off, 32'h1 << bits[i], "flag");
        end
        // Power-on with an external clock
        fire(por, 1'b0, pc + sc + rc, "por hold");
        waitfor(5, n);
        check("no clk delay", rng(n, 0, 3), 1);
        rchk(reg_cause_off, {16'h0, cause_rst_val}, "por flags");
        regulator_en <= 1'b0;
        fire(por, 1'b0, pc + pw + rc, "power_up_timer hold");
        regulator_en <= 1'b1;
        // Wake acts in run only; its count runs while wake is up
        waitfor(4, n);
        fire(7'b0, 1'b1, sc - 3, "wake hold");
        waitfor(5, n);
        // Short source during a power-on hold restarts it with the state-reset count
        pulse(por, 1'b0);
        fire(master_clear_pin, 1'b0, rc, "restart");
        waitfor(5, n);
        // Crystal: start-up count runs beside the reset delay
        osc_kind <= src_xtal;
        pulse(por, 1'b0);
        waitfor(7, n);
        check("held off", {31'h0, core_out.run}, 0);
        waitfor(5, m);
        check("ost", rng(n + m, 2 * ost_periods - 18,
            2 * ost_periods + 14), 1);
        // Monitoring follows the clock release by one cycle
        waitfor(4, n);
        check("mon on", rng(n, 1, 2), 1);
        check("no trap", {31'h0, core_out.osc_fail_trap}, 0);
        // Clock choice by reset type and switching
        osc_kind <= src_ext;
        clk_switch_en <= 1'b1;
        new_osc_config_field <= 3'h5;
        fire(por, 1'b0, pc + sc + rc, "sel hold");
        waitfor(5, n);
        check("sel por", {29'h0, core_out.clk_sel}, 5);
        rchk(reg_osc_off, 32'h5500, "osc por");
        new_osc_config_field <= 3'h2;
        fire(master_clear_pin, 1'b0, rc, "sel master_clear_pin");
        waitfor(5, n);
        check("sel cur", {29'h0, core_out.clk_sel}, 5);
        clk_switch_en <= 1'b0;
        fire(master_clear_pin, 1'b0, rc, "sel off");
        waitfor(5, n);
        check("sel cfg", {29'h0, core_out.clk_sel}, 2);
        // PLL with slow lock, then a dead clock at monitor start
        osc_kind <= src_ext_pll;
        lock_dly <= 8'd30;
        fire(por, 1'b0, pc + sc + rc, "pll hold");
        waitfor(5, n);
        check("lock first", {31'h0, pll_locked}, 1);
        osc_good <= 1'b0;
        fire(por, 1'b0, pc + sc + rc, "fail hold");
        waitfor(4, n);
        check("mon delay", rng(n, fc - 1, fc + 4), 1);
        repeat (3) @(negedge hclk);
        check("fail trap", {31'h0, core_out.osc_fail_trap}, 1);
        check("frc sel", {29'h0, core_out.clk_sel},
            {29'h0, osc_frc});
        rchk(reg_status_off, {24'h0, 2'b00, osc_frc, 3'b111},
            "status");
        results();
    end
endmodule
